// ==== tade_ctrl.sv ====
// How it works
// - Low-word word read returns program bits 15..0 unchanged.
// - Low-word byte read returns bits 7..0 or 15..8 by byte select.
// - High-word word read gives bits 23..16 in low byte, zero upper byte.
// - High-word byte read gives bits 23..16, or zero for byte select one.
// - Program address steps two per word; low and high share one range.
// - Upper program byte reachable only by high-word table access, not window.
// - A page of up to 16K words maps into upper data half.
// - EEPROM occupies program addresses 0x7FF000 through 0x7FFFFE, 2K words.
// - Single-word and aligned 16-word operations chosen by control register.
// - EEPROM location given by upper and lower address registers together.
// - A write takes nominally 2 ms; start bit stays set until done.
// - Writes run in background; no new start until current one ends.
// - EEPROM read during a write may return unspecified data.
// - Start bit set by software only; hardware clears it at completion.
// - Writes need the enable bit; it is clear after power-up.
// - Master-clear or watchdog cutting a write sets error; addresses kept.
// - Done flag set at write completion, held until software clears it.
// - Lower address register captures the last table write address; code takes only low-word EEPROM table writes while idle.
// - Write starts only after keys 0x55 then 0xAA.
// - No write may start while the power-up timer runs.
//
// Added by the designer: the address-and-strobe port and the register addresses.
module tade_ctrl #(
  parameter int unsigned EE_WORDS = tade_pkg::EE_WORDS,
  parameter int unsigned WRITE_CYCLES = tade_pkg::WRITE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire tade_pkg::tade_rbus_t reg_bus_i,
  output logic [15:0] reg_rdata_o,
  input wire tade_pkg::tade_tbl_req_t tbl_req_i,
  input wire tade_pkg::tade_win_req_t win_req_i,
  output logic [15:0] tbl_rdata_o,
  output logic tbl_rvalid_o,
  output logic [23:0] prog_addr_o,
  output logic prog_rd_o,
  input wire logic [23:0] prog_rdata_i,
  input wire logic master_clear_reset_i,
  input wire logic watchdog_timeout_i,
  input wire logic pwrt_running_i,
  output logic nv_done_irq_flag_o,
  output logic write_active_o
);
  // ==========================================================
  // Checks
  localparam int unsigned IDX_W = $clog2(EE_WORDS);
  localparam int unsigned SETTLE = 4;

  // Block index needs at least one bit above the in-block word index
  if (EE_WORDS <= tade_pkg::BLOCK_WORDS || EE_WORDS > tade_pkg::EE_WORDS ||
      (EE_WORDS & (EE_WORDS - 1)) != 0) begin : bad_ee_words
    $error("EE_WORDS must be a power of two between 32 and 4096");
  end
  if (WRITE_CYCLES < 1) begin : bad_write_cycles
    $error("WRITE_CYCLES must be at least one");
  end

  // ==========================================================
  // State
  typedef struct packed {
    tade_pkg::tade_nv_t nv;
    tade_pkg::tade_key_t key;
    logic write_permit_bit;
    logic write_abort_flag;
    logic [6:0] op;
    logic [15:0] adr_low;
    logic [7:0] adr_up;
    logic [7:0] tbl_page;
    logic win_on;
    logic [7:0] win_page;
    logic done;
    logic [31:0] tmr;
    logic [23:0] tgt;
    logic [15:0] rdata;
    logic pend;
    logic pend_high;
    logic pend_byte;
    logic pend_sel;
    logic pend_ee;
    logic [IDX_W-1:0] pend_idx;
    logic [15:0] tbl_rdata;
    logic rvalid;
    logic [23:0] prog_addr;
    logic prog_rd;
    logic [tade_pkg::BLOCK_WORDS-1:0][15:0] latch;
    logic [EE_WORDS-1:0][15:0] arr;
    logic [SETTLE-1:0] warm_up;
  } tade_state_t;

  tade_state_t r;
  tade_state_t next_r;
  logic [2:0] sync_lvl;
  logic pwrt_run;
  logic warm_rst;

  // ==========================================================
  // Pin inputs
  tade_sync #(
    .WIDTH(3)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({pwrt_running_i, watchdog_timeout_i, master_clear_reset_i}),
    .level_o(sync_lvl)
  );

  assign pwrt_run = sync_lvl[2];
  assign warm_rst = sync_lvl[1] | sync_lvl[0];

  // ==========================================================
  // Helpers
  function automatic logic is_ee(input logic [23:0] a);
    logic [23:0] off;
    off = a - tade_pkg::EE_BASE;
    return (a >= tade_pkg::EE_BASE) && (a <= tade_pkg::EE_LAST) &&
           (off[23:1] < 23'(EE_WORDS));
  endfunction

  function automatic logic [IDX_W-1:0] ee_idx(input logic [23:0] a);
    logic [23:0] off;
    off = a - tade_pkg::EE_BASE;
    return off[IDX_W:1];
  endfunction

  function automatic logic [15:0] fmt(input logic [23:0] w, input logic high, input logic bmode,
                                      input logic sel);
    logic [15:0] v;
    v = {tade_pkg::ZERO_BYTE, tade_pkg::ZERO_BYTE};
    if (!high) begin
      if (!bmode) begin
        v = w[tade_pkg::LSW_MSB:0];
      end else if (!sel) begin
        v = {tade_pkg::ZERO_BYTE, w[tade_pkg::BYTE_MSB:0]};
      end else begin
        v = {tade_pkg::ZERO_BYTE, w[tade_pkg::LSW_MSB:tade_pkg::BYTE1_LSB]};
      end
    end else if (!bmode || !sel) begin
      v = {tade_pkg::ZERO_BYTE, w[tade_pkg::MSB_MSB:tade_pkg::MSB_LSB]};
    end
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    logic [23:0] addr;
    logic [23:0] word;
    logic [IDX_W-1:0] tidx;
    logic [15:0] ctl;
    logic [15:0] wd;
    logic start_ok;
    addr = 24'h000000;
    word = 24'h000000;
    tidx = '0;
    ctl = 16'h0000;
    wd = reg_bus_i.wdata;
    start_ok = 1'b0;
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.prog_rd = 1'b0;
    next_r.pend = 1'b0;
    next_r.rdata = 16'h0000;
    // Synchroniser restarts at zero; its timer level is trusted only once filled
    next_r.warm_up = {r.warm_up[SETTLE-2:0], 1'b1};

    // Register read, answered one cycle later
    ctl[tade_pkg::CTRL_WR_BIT] = (r.nv == tade_pkg::NV_BUSY);
    ctl[tade_pkg::CTRL_WRITE_PERMIT_BIT_BIT] = r.write_permit_bit;
    ctl[tade_pkg::CTRL_WRITE_ABORT_FLAG_BIT] = r.write_abort_flag;
    ctl[tade_pkg::CTRL_OP_MSB:tade_pkg::CTRL_OP_LSB] = r.op;
    if (reg_bus_i.rd) begin
      unique case (reg_bus_i.addr)
        tade_pkg::REG_NONVOLATILE_CONTROL: next_r.rdata = ctl;
        tade_pkg::REG_NV_ADDRESS_LOW: next_r.rdata = r.adr_low;
        tade_pkg::REG_NV_ADDRESS_UPPER: next_r.rdata = {tade_pkg::ZERO_BYTE, r.adr_up};
        tade_pkg::REG_TABLE_PAGE_REG: next_r.rdata = {tade_pkg::ZERO_BYTE, r.tbl_page};
        tade_pkg::REG_WINDOW_CTRL: begin
          next_r.rdata[tade_pkg::WIN_ON_BIT] = r.win_on;
          next_r.rdata[tade_pkg::PAGE_MSB:0] = r.win_page;
        end
        tade_pkg::REG_IRQ_FLAG_STATUS_0: next_r.rdata[tade_pkg::IRQ_DONE_BIT] = r.done;
        default: next_r.rdata = 16'h0000;
      endcase
    end

    // Read pipe, second stage: format the fetched word
    if (r.pend) begin
      // Array content is returned even mid-write; software must not trust it then
      word = r.pend_ee ? {tade_pkg::ZERO_BYTE, r.arr[r.pend_idx]} : prog_rdata_i;
      next_r.tbl_rdata = fmt(word, r.pend_high, r.pend_byte, r.pend_sel);
      next_r.rvalid = 1'b1;
    end

    // Read pipe, first stage: table read has priority over the window
    if (tbl_req_i.valid && !tbl_req_i.write) begin
      addr = {r.tbl_page, tbl_req_i.ea};
      next_r.pend = 1'b1;
      next_r.pend_high = tbl_req_i.high;
      next_r.pend_byte = tbl_req_i.byte_mode;
      next_r.pend_sel = tbl_req_i.ea[0];
      next_r.pend_ee = is_ee(addr);
      next_r.pend_idx = ee_idx(addr);
      next_r.prog_rd = !is_ee(addr);
      next_r.prog_addr = addr;
    end else if (win_req_i.valid && r.win_on && win_req_i.ea[tade_pkg::WIN_SEL_BIT]) begin
      addr = {1'b0, r.win_page, win_req_i.ea[tade_pkg::WIN_EA_MSB:0]};
      next_r.pend = 1'b1;
      next_r.pend_high = 1'b0;
      next_r.pend_byte = win_req_i.byte_mode;
      next_r.pend_sel = win_req_i.ea[0];
      next_r.pend_ee = is_ee(addr);
      next_r.pend_idx = ee_idx(addr);
      next_r.prog_rd = !is_ee(addr);
      next_r.prog_addr = addr;
    end

    // Table write low into the EEPROM latches; frozen while a write runs
    addr = {r.tbl_page, tbl_req_i.ea};
    if (tbl_req_i.valid && tbl_req_i.write && !tbl_req_i.high && is_ee(addr) &&
        r.nv == tade_pkg::NV_IDLE) begin
      tidx = ee_idx(addr);
      next_r.latch[tidx[tade_pkg::BLK_BITS-1:0]] = tbl_req_i.wdata;
      next_r.adr_low = tbl_req_i.ea;
      next_r.adr_up = r.tbl_page;
    end

    // Register writes
    if (reg_bus_i.wr) begin
      unique case (reg_bus_i.addr)
        tade_pkg::REG_NONVOLATILE_CONTROL: begin
          next_r.write_permit_bit = wd[tade_pkg::CTRL_WRITE_PERMIT_BIT_BIT];
          next_r.write_abort_flag = wd[tade_pkg::CTRL_WRITE_ABORT_FLAG_BIT];
          if (r.nv == tade_pkg::NV_IDLE) begin
            next_r.op = wd[tade_pkg::CTRL_OP_MSB:tade_pkg::CTRL_OP_LSB];
          end
          start_ok = wd[tade_pkg::CTRL_WR_BIT] && wd[tade_pkg::CTRL_WRITE_PERMIT_BIT_BIT] &&
                     r.key == tade_pkg::KEY_OPEN &&
                     !pwrt_run && r.warm_up[SETTLE-1] &&
                     r.nv == tade_pkg::NV_IDLE;
          if (start_ok) begin
            next_r.nv = tade_pkg::NV_BUSY;
            next_r.tmr = 32'h0000_0000;
            next_r.tgt = {r.adr_up, r.adr_low};
          end
          // Any control write spends the unlock, so a stray set needs fresh keys
          next_r.key = tade_pkg::KEY_IDLE;
        end
        tade_pkg::REG_NV_ADDRESS_LOW: next_r.adr_low = wd;
        tade_pkg::REG_NV_ADDRESS_UPPER: next_r.adr_up = wd[tade_pkg::PAGE_MSB:0];
        tade_pkg::REG_NV_UNLOCK_KEY: begin
          if (wd[tade_pkg::KEY_MSB:0] == tade_pkg::KEY_FIRST_VAL) begin
            next_r.key = tade_pkg::KEY_FIRST;
          end else if (r.key == tade_pkg::KEY_FIRST &&
                       wd[tade_pkg::KEY_MSB:0] == tade_pkg::KEY_SECOND_VAL) begin
            next_r.key = tade_pkg::KEY_OPEN;
          end else begin
            next_r.key = tade_pkg::KEY_IDLE;
          end
        end
        tade_pkg::REG_TABLE_PAGE_REG: next_r.tbl_page = wd[tade_pkg::PAGE_MSB:0];
        tade_pkg::REG_WINDOW_CTRL: begin
          next_r.win_on = wd[tade_pkg::WIN_ON_BIT];
          next_r.win_page = wd[tade_pkg::PAGE_MSB:0];
        end
        tade_pkg::REG_IRQ_FLAG_STATUS_0: next_r.done = wd[tade_pkg::IRQ_DONE_BIT];
        default: begin
        end
      endcase
    end

    // Background write timer; the core keeps issuing reads meanwhile
    if (r.nv == tade_pkg::NV_BUSY) begin
      if (r.tmr == 32'(WRITE_CYCLES - 1)) begin
        if (is_ee(r.tgt)) begin
          tidx = ee_idx(r.tgt);
          unique case (r.op)
            tade_pkg::OP_WORD_WRITE: next_r.arr[tidx] = r.latch[tidx[tade_pkg::BLK_BITS-1:0]];
            tade_pkg::OP_WORD_ERASE: next_r.arr[tidx] = tade_pkg::ERASED_WORD;
            tade_pkg::OP_BLOCK_WRITE: begin
              for (int k = 0; k < tade_pkg::BLOCK_WORDS; k++) begin
                next_r.arr[{tidx[IDX_W-1:tade_pkg::BLK_BITS], 4'(k)}] = r.latch[k];
              end
            end
            tade_pkg::OP_BLOCK_ERASE: begin
              for (int k = 0; k < tade_pkg::BLOCK_WORDS; k++) begin
                next_r.arr[{tidx[IDX_W-1:tade_pkg::BLK_BITS], 4'(k)}] = tade_pkg::ERASED_WORD;
              end
            end
            default: begin
            end
          endcase
        end
        next_r.nv = tade_pkg::NV_IDLE;
        next_r.done = 1'b1;
      end else begin
        next_r.tmr = r.tmr + 32'h0000_0001;
      end
    end

    // Warm reset cuts a running write; addresses and array stay as they are
    if (warm_rst) begin
      if (r.nv == tade_pkg::NV_BUSY) begin
        next_r.write_abort_flag = 1'b1;
      end
      next_r.nv = tade_pkg::NV_IDLE;
      next_r.tmr = 32'h0000_0000;
      next_r.key = tade_pkg::KEY_IDLE;
      next_r.pend = 1'b0;
      next_r.rvalid = 1'b0;
      next_r.prog_rd = 1'b0;
    end

    // Power-up: array starts erased, enable bit clear
    if (sys_rst_i) begin
      next_r = '0;
      next_r.nv = tade_pkg::NV_IDLE;
      next_r.key = tade_pkg::KEY_IDLE;
      next_r.latch = {tade_pkg::BLOCK_WORDS{tade_pkg::ERASED_WORD}};
      next_r.arr = {EE_WORDS{tade_pkg::ERASED_WORD}};
    end
  end

  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = r.rdata;
  assign tbl_rdata_o = r.tbl_rdata;
  assign tbl_rvalid_o = r.rvalid;
  assign prog_addr_o = r.prog_addr;
  assign prog_rd_o = r.prog_rd;
  assign nv_done_irq_flag_o = r.done;
  assign write_active_o = (r.nv == tade_pkg::NV_BUSY);
endmodule

// ==== tade_pkg.sv ====
package tade_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned WRITE_TIME_MS = 2;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;

  // ==========================================================
  // Register indices
  localparam int unsigned REG_AW = 4;
  localparam logic [REG_AW-1:0] REG_NONVOLATILE_CONTROL = 4'h0;
  localparam logic [REG_AW-1:0] REG_NV_ADDRESS_LOW = 4'h1;
  localparam logic [REG_AW-1:0] REG_NV_ADDRESS_UPPER = 4'h2;
  localparam logic [REG_AW-1:0] REG_NV_UNLOCK_KEY = 4'h3;
  localparam logic [REG_AW-1:0] REG_TABLE_PAGE_REG = 4'h4;
  localparam logic [REG_AW-1:0] REG_WINDOW_CTRL = 4'h5;
  localparam logic [REG_AW-1:0] REG_IRQ_FLAG_STATUS_0 = 4'h6;

  // ==========================================================
  // Field layouts
  localparam int unsigned CTRL_WR_BIT = 15;
  localparam int unsigned CTRL_WRITE_PERMIT_BIT_BIT = 14;
  localparam int unsigned CTRL_WRITE_ABORT_FLAG_BIT = 13;
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_OP_MSB = 6;
  localparam int unsigned IRQ_DONE_BIT = 0;
  localparam int unsigned WIN_ON_BIT = 15;
  localparam int unsigned PAGE_MSB = 7;
  localparam int unsigned KEY_MSB = 7;
  localparam int unsigned BYTE_MSB = 7;
  localparam int unsigned BYTE1_LSB = 8;
  localparam int unsigned LSW_MSB = 15;
  localparam int unsigned MSB_LSB = 16;
  localparam int unsigned MSB_MSB = 23;
  localparam int unsigned WIN_SEL_BIT = 15;
  localparam int unsigned WIN_EA_MSB = 14;
  localparam int unsigned BLK_BITS = 4;

  // ==========================================================
  // Operation codes and keys
  localparam logic [6:0] OP_WORD_WRITE = 7'h04;
  localparam logic [6:0] OP_BLOCK_WRITE = 7'h0a;
  localparam logic [6:0] OP_WORD_ERASE = 7'h44;
  localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
  localparam logic [7:0] KEY_FIRST_VAL = 8'h55;
  localparam logic [7:0] KEY_SECOND_VAL = 8'haa;

  // ==========================================================
  // EEPROM map
  localparam logic [23:0] EE_BASE = 24'h7ff000;
  localparam logic [23:0] EE_LAST = 24'h7ffffe;
  localparam int unsigned EE_WORDS = 4096;
  localparam int unsigned BLOCK_WORDS = 16;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ==========================================================
  // States
  typedef enum logic {NV_IDLE, NV_BUSY} tade_nv_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_OPEN} tade_key_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [REG_AW-1:0] addr;
    logic [15:0] wdata;
  } tade_rbus_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic high;
    logic byte_mode;
    logic [15:0] ea;
    logic [15:0] wdata;
  } tade_tbl_req_t;

  typedef struct packed {
    logic valid;
    logic byte_mode;
    logic [15:0] ea;
  } tade_win_req_t;
endpackage

// ==== tade_sync.sv ====
module tade_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] level_o
);
  // ==========================================================
  // Checks
  if (WIDTH < 1) begin : bad_width
    $error("tade_sync width must be at least one");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } tade_sync_state_t;

  tade_sync_state_t r;
  tade_sync_state_t next_r;

  // Level moves only when the two settled stages agree, so one glitch never counts
  always_comb begin
    next_r = r;
    next_r.s1 = async_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.lvl[i] = r.s3[i];
      end
    end
    if (sys_rst_i) begin
      next_r = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    r <= next_r;
  end

  assign level_o = r.lvl;
endmodule

// ==== tade_pmem.sv ====
module tade_pmem (
  input wire logic [23:0] prog_addr_i,
  input wire logic prog_rd_i,
  output logic [23:0] prog_rdata_o
);
  // ==========
  // Program word contents
  // Three bytes differ from each other, so a swapped byte lane shows up
  function automatic logic [23:0] word_at(input logic [23:0] a);
    return {a[15:8] ^ 8'h5a, a[8:1] ^ 8'hc3, a[16:9] ^ 8'h96};
  endfunction

  // ==========
  // Read port
  // Outside a read cycle the bus shows the inverse, so a late sample cannot match by luck
  assign prog_rdata_o = prog_rd_i ? word_at(prog_addr_i) : ~word_at(prog_addr_i);
endmodule

// ==== tade_ctrl_monitor.sv ====
module tade_ctrl_monitor #(
  parameter int unsigned EE_WORDS = tade_pkg::EE_WORDS,
  parameter int unsigned WRITE_CYCLES = tade_pkg::WRITE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire tade_pkg::tade_rbus_t reg_bus_i,
  input wire logic [15:0] reg_rdata_o,
  input wire tade_pkg::tade_tbl_req_t tbl_req_i,
  input wire tade_pkg::tade_win_req_t win_req_i,
  input wire logic [15:0] tbl_rdata_o,
  input wire logic tbl_rvalid_o,
  input wire logic [23:0] prog_addr_o,
  input wire logic prog_rd_o,
  input wire logic [23:0] prog_rdata_i,
  input wire logic master_clear_reset_i,
  input wire logic watchdog_timeout_i,
  input wire logic pwrt_running_i,
  input wire logic nv_done_irq_flag_o,
  input wire logic write_active_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========
  // Helper state
  logic [31:0] busy_cnt;
  logic [7:0] last_key;
  logic warm;
  assign warm = master_clear_reset_i || watchdog_timeout_i;
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      busy_cnt <= '0;
      last_key <= '0;
    end else begin
      busy_cnt <= write_active_o ? busy_cnt + 32'h1 : '0;
      if (reg_bus_i.wr && reg_bus_i.addr == tade_pkg::REG_NV_UNLOCK_KEY) begin
        last_key <= reg_bus_i.wdata[7:0];
      end else if (reg_bus_i.wr && reg_bus_i.addr == tade_pkg::REG_NONVOLATILE_CONTROL) begin
        last_key <= '0;
      end
    end
  end

  // ==========
  // Sequences
  sequence s_low_word;
    tbl_req_i.valid && !tbl_req_i.write && !tbl_req_i.high && !tbl_req_i.byte_mode ##1 prog_rd_o;
  endsequence
  sequence s_go;
    reg_bus_i.wr && reg_bus_i.addr == tade_pkg::REG_NONVOLATILE_CONTROL && reg_bus_i.wdata[15:14] == 2'b11;
  endsequence

  // ==========
  // Properties
  property p_start;
    $rose(write_active_o) |-> $past(reg_bus_i.wr && reg_bus_i.addr == tade_pkg::REG_NONVOLATILE_CONTROL
      && reg_bus_i.wdata[15:14] == 2'b11);
  endproperty
  a_start: assert property (p_start) else $error("write began without an enabled start");
  property p_key;
    s_go ##1 $rose(write_active_o) |-> $past(last_key, 1) == 8'haa;
  endproperty
  a_key: assert property (p_key) else $error("write began without the unlock keys");
  property p_dur;
    $fell(write_active_o) && !warm |-> busy_cnt == WRITE_CYCLES;
  endproperty
  a_dur: assert property (p_dur) else $error("write length wrong");
  property p_done;
    $fell(write_active_o) && !warm |-> nv_done_irq_flag_o;
  endproperty
  a_done: assert property (p_done) else $error("done flag missing at write end");
  property p_pwrt;
    (pwrt_running_i [*6]) |-> !$rose(write_active_o);
  endproperty
  a_pwrt: assert property (p_pwrt) else $error("write began under power-up timer");
  property p_low;
    s_low_word |=> tbl_rvalid_o && tbl_rdata_o == $past(prog_rdata_i[15:0]);
  endproperty
  a_low: assert property (p_low) else $error("low word read differs");
  property p_high;
    tbl_req_i.valid && !tbl_req_i.write && tbl_req_i.high && !tbl_req_i.byte_mode
      |-> ##2 tbl_rvalid_o && tbl_rdata_o[15:8] == 8'h00;
  endproperty
  a_high: assert property (p_high) else $error("high word read upper byte not zero");
  property p_high_b1;
    tbl_req_i.valid && !tbl_req_i.write && tbl_req_i.high && tbl_req_i.byte_mode && tbl_req_i.ea[0]
      |-> ##2 tbl_rvalid_o && tbl_rdata_o == 16'h0000;
  endproperty
  a_high_b1: assert property (p_high_b1) else $error("high byte one not zero");
  property p_ee_local;
    prog_rd_o |-> !(prog_addr_o >= tade_pkg::EE_BASE && prog_addr_o <= tade_pkg::EE_LAST);
  endproperty
  a_ee_local: assert property (p_ee_local) else $error("EEPROM address sent to program memory");
  property p_win_low;
    win_req_i.valid && !win_req_i.ea[15] && !tbl_req_i.valid |-> ##2 !tbl_rvalid_o;
  endproperty
  a_win_low: assert property (p_win_low) else $error("window read below upper half answered");
endmodule

bind tade_ctrl tade_ctrl_monitor #(.EE_WORDS(EE_WORDS), .WRITE_CYCLES(WRITE_CYCLES)) u_mon (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_bus_i(reg_bus_i), .reg_rdata_o(reg_rdata_o),
  .tbl_req_i(tbl_req_i), .win_req_i(win_req_i), .tbl_rdata_o(tbl_rdata_o), .tbl_rvalid_o(tbl_rvalid_o),
  .prog_addr_o(prog_addr_o), .prog_rd_o(prog_rd_o), .prog_rdata_i(prog_rdata_i),
  .master_clear_reset_i(master_clear_reset_i), .watchdog_timeout_i(watchdog_timeout_i),
  .pwrt_running_i(pwrt_running_i), .nv_done_irq_flag_o(nv_done_irq_flag_o), .write_active_o(write_active_o));

// ==== tb_table_access_data_eeprom_ctrl.sv ====
module tb_table_access_data_eeprom_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  // Short write time keeps the run small; checks use the same figure
  localparam int unsigned WC = 20;
  localparam logic [3:0] CTL = tade_pkg::REG_NONVOLATILE_CONTROL;
  localparam logic [3:0] KEY = tade_pkg::REG_NV_UNLOCK_KEY;
  localparam logic [3:0] ADL = tade_pkg::REG_NV_ADDRESS_LOW;
  localparam logic [3:0] IRQ = tade_pkg::REG_IRQ_FLAG_STATUS_0;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  tade_pkg::tade_rbus_t bus = '0;
  tade_pkg::tade_tbl_req_t tbl = '0;
  tade_pkg::tade_win_req_t win = '0;
  logic [15:0] reg_rdata, tbl_rdata;
  logic tbl_rvalid, prog_rd, done_flag, active;
  logic [23:0] prog_addr, prog_rdata;
  logic master_clear_reset = 1'b0;
  logic wdt = 1'b0;
  logic pwrt = 1'b1;
  int n_fail = 0;
  int comparisons = 0;

  always #50 core_clk_i = ~core_clk_i;

  tade_ctrl #(.WRITE_CYCLES(WC)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_bus_i(bus),
    .reg_rdata_o(reg_rdata), .tbl_req_i(tbl), .win_req_i(win), .tbl_rdata_o(tbl_rdata),
    .tbl_rvalid_o(tbl_rvalid), .prog_addr_o(prog_addr), .prog_rd_o(prog_rd), .prog_rdata_i(prog_rdata),
    .master_clear_reset_i(master_clear_reset), .watchdog_timeout_i(wdt), .pwrt_running_i(pwrt),
    .nv_done_irq_flag_o(done_flag), .write_active_o(active));
  tade_pmem pm (.prog_addr_i(prog_addr), .prog_rd_i(prog_rd), .prog_rdata_o(prog_rdata));

  // ==========
  // Access tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= {1'b1, 1'b0, a, d};
    @(posedge core_clk_i);
    bus <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge core_clk_i);
    bus <= '0;
    #1;
    chk("reg_rdata_o", exp, reg_rdata);
    @(posedge core_clk_i);
  endtask
  task automatic trd(input logic w, input logic h, input logic b, input logic [15:0] ea, input logic ok,
                     input logic [15:0] exp);
    if (w) win <= {1'b1, b, ea};
    else tbl <= {1'b1, 1'b0, h, b, ea, 16'h0000};
    @(posedge core_clk_i);
    tbl <= '0;
    win <= '0;
    @(posedge core_clk_i);
    #1;
    chk("tbl_rvalid_o", {15'h0000, ok}, {15'h0000, tbl_rvalid});
    if (ok) chk("tbl_rdata_o", exp, tbl_rdata);
    @(posedge core_clk_i);
  endtask
  task automatic twr(input logic [15:0] ea, input logic [15:0] d);
    tbl <= {1'b1, 1'b1, 1'b0, 1'b0, ea, d};
    @(posedge core_clk_i);
    tbl <= '0;
    @(posedge core_clk_i);
  endtask
  task automatic unlock_go(input logic [15:0] ctl_val);
    wr(KEY, 16'h0055);
    wr(KEY, 16'h00aa);
    wr(CTL, ctl_val);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    #1;
    while (active === 1'b1 && n < 200) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    chk("write_active_o", 16'h0000, {15'h0000, active});
    @(posedge core_clk_i);
  endtask
  function automatic logic [15:0] fmt(input logic [23:0] p, input logic h, input logic b, input logic s);
    case ({h, b})
      2'b00: return p[15:0];
      2'b01: return s ? {8'h00, p[15:8]} : {8'h00, p[7:0]};
      2'b10: return {8'h00, p[23:16]};
      default: return s ? 16'h0000 : {8'h00, p[23:16]};
    endcase
  endfunction

  task close_out;
    $display("Comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========
  // Watchdog
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end

  // ==========
  // Tests
  initial begin
    logic [15:0] ea;
    repeat (8) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(CTL, 16'h0000);
    wr(4'hf, 16'hbeef);
    rd(4'hf, 16'h0000);
    wr(tade_pkg::REG_TABLE_PAGE_REG, 16'h0012);
    for (int m = 0; m < 8; m++) begin
      ea = 16'h0a40 + 16'(m);
      trd(1'b0, m[2], m[1], ea, 1'b1, fmt(pm.word_at({8'h12, ea}), m[2], m[1], m[0]));
    end
    wr(tade_pkg::REG_WINDOW_CTRL, 16'h8034);
    trd(1'b1, 1'b0, 1'b0, 16'h8246, 1'b1, pm.word_at(24'h1a0246) & 16'hffff);
    trd(1'b1, 1'b0, 1'b1, 16'h8247, 1'b1, fmt(pm.word_at(24'h1a0246), 1'b0, 1'b1, 1'b1));
    trd(1'b1, 1'b0, 1'b0, 16'h0246, 1'b0, 16'h0000);
    // Far side keeps erased words before word writes
    wr(tade_pkg::REG_TABLE_PAGE_REG, 16'h007f);
    twr(16'hf010, 16'h1234);
    rd(ADL, 16'hf010);
    rd(tade_pkg::REG_NV_ADDRESS_UPPER, 16'h007f);
    unlock_go(16'hc004);
    rd(CTL, 16'h4004);
    pwrt <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    wr(CTL, 16'hc004);
    rd(CTL, 16'h4004);
    trd(1'b0, 1'b0, 1'b0, 16'hf010, 1'b1, tade_pkg::ERASED_WORD);
    wr(CTL, 16'h0004);
    unlock_go(16'h8004);
    rd(CTL, 16'h0004);
    unlock_go(16'hc004);
    rd(CTL, 16'hc004);
    wr(CTL, 16'h4004);
    rd(CTL, 16'hc004);
    unlock_go(16'hc044);
    rd(CTL, 16'hc004);
    wait_idle();
    chk("nv_done_irq_flag_o", 16'h0001, {15'h0000, done_flag});
    rd(IRQ, 16'h0001);
    trd(1'b0, 1'b0, 1'b0, 16'hf010, 1'b1, 16'h1234);
    trd(1'b0, 1'b1, 1'b0, 16'hf010, 1'b1, 16'h0000);
    rd(IRQ, 16'h0001);
    wr(IRQ, 16'h0000);
    rd(IRQ, 16'h0000);
    chk("nv_done_irq_flag_o", 16'h0000, {15'h0000, done_flag});
    for (int i = 0; i < 16; i++) twr(16'hf020 + 16'(2 * i), 16'ha500 + 16'(i));
    rd(ADL, 16'hf03e);
    wr(CTL, 16'h400a);
    unlock_go(16'hc00a);
    wait_idle();
    for (int i = 0; i < 16; i++) trd(1'b0, 1'b0, 1'b0, 16'hf020 + 16'(2 * i), 1'b1, 16'ha500 + 16'(i));
    for (int k = 0; k < 2; k++) begin
      twr(16'hf040, 16'h7777);
      unlock_go(16'hc004);
      repeat (3) @(posedge core_clk_i);
      if (k == 0) master_clear_reset <= 1'b1;
      else wdt <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      master_clear_reset <= 1'b0;
      wdt <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      rd(CTL, 16'h6004);
      rd(ADL, 16'hf040);
      wr(CTL, 16'h4004);
    end
    close_out();
  end
endmodule
